// ==== mfs_top.sv ====
// MAC frame statistics: one report vector per frame sent and per frame
// received, per-cycle byte counts, and the two link fault flags.
// Assumes the datapath taps are on clock; the fault inputs are pins.
`timescale 1ns/1ps
`include "mfs_defs.svh"

module mfs_top #(
	parameter int LANES = 8
) (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic [63:0]           tx_data,
	input  wire logic [7:0]            tx_lanes,
	input  wire logic                  tx_first,
	input  wire logic                  tx_last,
	input  wire logic                  tx_underrun,
	input  wire logic                  tx_error,
	input  wire logic                  tx_pause_gen,
	input  wire logic                  tx_vlan_en,
	output logic [`MFS_TX_W-1:0]       tx_stats_vector,
	output logic                       tx_stats_vld,
	input  wire logic [63:0]           rx_data,
	input  wire logic [7:0]            rx_lanes,
	input  wire logic                  rx_first,
	input  wire logic                  rx_last,
	input  wire logic                  rx_fcs_bad,
	input  wire logic                  rx_code_err,
	input  wire logic                  rx_vlan_en,
	input  wire logic                  rx_jumbo_en,
	input  wire logic                  rx_lt_check_dis,
	input  wire logic                  rx_fc_en,
	input  wire logic [47:0]           rx_pause_addr,
	output logic [`MFS_RX_W-1:0]       rx_stats_vector,
	output logic                       rx_stats_vld,
	input  wire logic                  local_fault_pin,
	input  wire logic                  remote_fault_pin,
	output logic [1:0]                 link_fault_status
);
	// Header positions are fixed to an eight-lane datapath
	generate
		if (LANES != 8) begin : g_lane_check
			$error("mfs_top supports only LANES = 8");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Datapath taps and per-side helpers
	mfs_beat_if tx_beat ();
	mfs_beat_if rx_beat ();

	assign tx_beat.data  = tx_data;
	assign tx_beat.lanes = tx_lanes;
	assign tx_beat.first = tx_first;
	assign tx_beat.last  = tx_last;
	assign rx_beat.data  = rx_data;
	assign rx_beat.lanes = rx_lanes;
	assign rx_beat.first = rx_first;
	assign rx_beat.last  = rx_last;

	logic        tx_mcast;
	logic        tx_bcast;
	logic        tx_tag;
	logic [15:0] tx_lt;
	logic [15:0] tx_total;
	logic        rx_mcast;
	logic        rx_bcast;
	logic [47:0] rx_da;
	logic        rx_tag;
	logic [15:0] rx_lt;
	logic [15:0] rx_opc;
	logic [15:0] rx_total;

	mfs_hdr_parse u_tx_hdr (
		.clock    (clock),
		.rst      (rst),
		.beat     (tx_beat),
		.da_mcast (tx_mcast),
		.da_bcast (tx_bcast),
		.da       (),
		.vlan_tag (tx_tag),
		.lt_field (tx_lt),
		.opcode   ()
	);

	mfs_hdr_parse u_rx_hdr (
		.clock    (clock),
		.rst      (rst),
		.beat     (rx_beat),
		.da_mcast (rx_mcast),
		.da_bcast (rx_bcast),
		.da       (rx_da),
		.vlan_tag (rx_tag),
		.lt_field (rx_lt),
		.opcode   (rx_opc)
	);

	mfs_len_count u_tx_len (
		.clock (clock),
		.rst   (rst),
		.beat  (tx_beat),
		.total (tx_total)
	);

	mfs_len_count u_rx_len (
		.clock (clock),
		.rst   (rst),
		.beat  (rx_beat),
		.total (rx_total)
	);

	////////////////////////////////////////////////////////////////////////
	// Send side
	logic                 tx_end;
	logic [25:0]          tx_rep_r;
	logic [3:0]           tx_bv_r;
	logic                 tx_vld_r;
	logic [14:0]          tx_len;

	assign tx_end = tx_last && (|tx_lanes);
	assign tx_len = (tx_total > `MFS_LEN_JUMBO_CAP) ? 15'h7FFF : tx_total[14:0];

	// Frame report fields, loaded once as the frame's last beat passes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_rep_r <= 26'h000_0000;
		end else if (tx_end) begin
			tx_rep_r                            <= 26'h000_0000;
			tx_rep_r[`MFS_TX_PAUSE]             <= tx_pause_gen;
			tx_rep_r[`MFS_TX_VLAN]              <= tx_tag && tx_vlan_en;
			tx_rep_r[`MFS_LEN_MSB:`MFS_LEN_LSB] <= tx_len;
			tx_rep_r[`MFS_TX_CTRL]              <= (tx_lt == `MFS_TYPE_CTRL);
			tx_rep_r[`MFS_TX_UNDERRUN]          <= tx_underrun;
			tx_rep_r[`MFS_TX_MCAST]             <= tx_mcast;
			tx_rep_r[`MFS_TX_BCAST]             <= tx_bcast;
			tx_rep_r[`MFS_TX_OK]                <= !tx_underrun && !tx_error;
		end
	end

	// Strobe lands the cycle after the last beat, together with the fields
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_vld_r <= 1'b0;
		end else begin
			tx_vld_r <= tx_end;
		end
	end

	// Byte count comes from the lane taps, not the report stage
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_bv_r <= 4'h0;
		end else begin
			tx_bv_r <= mfs_pkg::lane_count(tx_lanes);
		end
	end

	// Count is merged in every cycle; other fields only change at frame end
	always_comb begin
		tx_stats_vector                             = tx_rep_r;
		tx_stats_vector[`MFS_TX_BV_MSB:`MFS_TX_BV_LSB] = tx_bv_r;
	end
	assign tx_stats_vld = tx_vld_r;

	////////////////////////////////////////////////////////////////////////
	// Receive side
	logic        rx_end;
	logic [15:0] rx_cap;
	logic        rx_over;
	logic        rx_ctrl;
	logic [15:0] rx_hdr;
	logic [15:0] rx_client;
	logic        rx_lt_err;
	logic        rx_good;
	logic        rx_fcs_err;
	logic [29:0] rx_rep_r;
	logic [3:0]  rx_bv_r;
	logic        rx_vld_r;

	assign rx_end = rx_last && (|rx_lanes);

	// Frame checks; jumbo frames lift the standard cap, tags add four bytes to it when rx_vlan_en is set
	always_comb begin
		if (rx_jumbo_en) begin
			rx_cap = `MFS_LEN_JUMBO_CAP;
		end else if (rx_tag && rx_vlan_en) begin
			rx_cap = `MFS_LEN_VLAN_CAP;
		end else begin
			rx_cap = `MFS_LEN_STD_CAP;
		end
		rx_over    = !rx_jumbo_en && (rx_total > rx_cap);
		rx_ctrl    = (rx_lt == `MFS_TYPE_CTRL);
		rx_hdr     = `MFS_HDR_FCS_LEN + (rx_tag ? `MFS_TAG_LEN : 16'h0000);
		rx_client  = (rx_total > rx_hdr) ? rx_total - rx_hdr : 16'h0000;
		rx_lt_err  = 1'b0;
		if (!rx_lt_check_dis && (rx_lt < `MFS_TYPE_MIN)) begin
			if (rx_lt < `MFS_PAD_LIMIT) begin
				rx_lt_err = (rx_total != `MFS_CTRL_LEN);
			end else begin
				rx_lt_err = (rx_client != rx_lt);
			end
		end
		rx_fcs_err = rx_fcs_bad || rx_code_err;
		rx_good    = !rx_fcs_err && !rx_lt_err && !rx_over &&
		             !(rx_ctrl && (rx_total != `MFS_CTRL_LEN));
	end

	// Frame report fields, loaded once as the frame's last beat passes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_rep_r <= 30'h0000_0000;
		end else if (rx_end) begin
			rx_rep_r                            <= 30'h0000_0000;
			rx_rep_r[`MFS_RX_LT_ERR]            <= rx_lt_err;
			rx_rep_r[`MFS_RX_BAD_OPC]           <= rx_good && rx_ctrl && (rx_opc != `MFS_OPC_PAUSE);
			rx_rep_r[`MFS_RX_FLOW]              <= rx_good && rx_ctrl && rx_fc_en &&
			                                       (rx_opc == `MFS_OPC_PAUSE) &&
			                                       ((rx_da == `MFS_CTRL_MCAST) || (rx_da == rx_pause_addr));
			rx_rep_r[`MFS_RX_VLAN]              <= rx_tag && rx_vlan_en;
			rx_rep_r[`MFS_RX_OVERSIZE]          <= rx_over;
			rx_rep_r[`MFS_RX_CTRL]              <= rx_ctrl;
			rx_rep_r[`MFS_LEN_MSB:`MFS_LEN_LSB] <= (rx_total > rx_cap) ? rx_cap[14:0] : rx_total[14:0];
			rx_rep_r[`MFS_RX_MCAST]             <= rx_mcast;
			rx_rep_r[`MFS_RX_BCAST]             <= rx_bcast;
			rx_rep_r[`MFS_RX_FCS_ERR]           <= rx_fcs_err;
			rx_rep_r[`MFS_RX_BAD]               <= !rx_good;
			rx_rep_r[`MFS_RX_GOOD]              <= rx_good;
		end
	end

	// Strobe lands the cycle after the last beat, together with the fields
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_vld_r <= 1'b0;
		end else begin
			rx_vld_r <= rx_end;
		end
	end

	// Per-cycle byte count, independent of the strobe
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_bv_r <= 4'h0;
		end else begin
			rx_bv_r <= mfs_pkg::lane_count(rx_lanes);
		end
	end

	always_comb begin
		rx_stats_vector                                = rx_rep_r;
		rx_stats_vector[`MFS_RX_BV_MSB:`MFS_RX_BV_LSB] = rx_bv_r;
	end
	assign rx_stats_vld = rx_vld_r;

	////////////////////////////////////////////////////////////////////////
	// Link fault flags; pins are asynchronous, so two stages before use
	logic [1:0] fault_s1_r;
	logic [1:0] fault_s2_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fault_s1_r <= 2'h0;
			fault_s2_r <= 2'h0;
		end else begin
			fault_s1_r <= {remote_fault_pin, local_fault_pin};
			fault_s2_r <= fault_s1_r;
		end
	end
	assign link_fault_status = fault_s2_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_tx_strobe_cause: assert property (@(posedge clock) disable iff (rst)
		tx_stats_vld |-> $past(tx_last) && ($past(tx_lanes) != 8'h00))
		else $error("send strobe without a finished frame");

	a_tx_strobe_pulse: assert property (@(posedge clock) disable iff (rst)
		tx_stats_vld && !(tx_last && |tx_lanes) |=> !tx_stats_vld)
		else $error("send strobe longer than one cycle");

	a_tx_bytes_count: assert property (@(posedge clock) disable iff (rst)
		##1 tx_stats_vector[24:21] == mfs_pkg::lane_count($past(tx_lanes)))
		else $error("send byte count does not follow lanes");

	a_tx_len_sat: assert property (@(posedge clock) disable iff (rst)
		tx_end && (tx_total > 16'h7FFF) |=> tx_stats_vector[19:5] == 15'h7FFF)
		else $error("send length not saturated");

	a_tx_pause_flag: assert property (@(posedge clock) disable iff (rst)
		tx_end |=> tx_stats_vector[25] == $past(tx_pause_gen))
		else $error("pause flag does not follow generator");

	a_rx_good_bad: assert property (@(posedge clock) disable iff (rst)
		rx_stats_vld |-> (rx_stats_vector[0] != rx_stats_vector[1]) && (!rx_stats_vector[2] || rx_stats_vector[1]))
		else $error("receive good and bad flags inconsistent");

	a_rx_flow_good: assert property (@(posedge clock) disable iff (rst)
		rx_stats_vld && rx_stats_vector[27] |-> rx_stats_vector[0] && rx_stats_vector[20])
		else $error("flow control flag on a bad or non-control frame");

	a_rx_len_cap: assert property (@(posedge clock) disable iff (rst)
		rx_end && !rx_jumbo_en |=> rx_stats_vector[19:5] <= 15'h05F2)
		else $error("receive length above the standard cap");

	a_rx_oversize_jumbo: assert property (@(posedge clock) disable iff (rst)
		rx_end && rx_jumbo_en |=> !rx_stats_vector[21])
		else $error("oversize flagged with jumbo enabled");

	a_fault_follow: assert property (@(posedge clock) disable iff (rst)
		!$past(rst) && !$past(rst, 2) |-> link_fault_status == $past({remote_fault_pin, local_fault_pin}, 2))
		else $error("fault flags do not follow pins");
endmodule

// ==== mfs_defs.svh ====
// Constants for the MAC frame statistics block: report bit positions,
// frame length limits, type codes and addresses.
// Assumes it is included by bare name wherever the constants are needed.
`ifndef MFS_DEFS_SVH
`define MFS_DEFS_SVH

// Send report layout
`define MFS_TX_W          26
`define MFS_TX_PAUSE      25
`define MFS_TX_BV_MSB     24
`define MFS_TX_BV_LSB     21
`define MFS_TX_VLAN       20
`define MFS_TX_CTRL       4
`define MFS_TX_UNDERRUN   3
`define MFS_TX_MCAST      2
`define MFS_TX_BCAST      1
`define MFS_TX_OK         0

// Receive report layout
`define MFS_RX_W          30
`define MFS_RX_LT_ERR     29
`define MFS_RX_BAD_OPC    28
`define MFS_RX_FLOW       27
`define MFS_RX_BV_MSB     26
`define MFS_RX_BV_LSB     23
`define MFS_RX_VLAN       22
`define MFS_RX_OVERSIZE   21
`define MFS_RX_CTRL       20
`define MFS_RX_MCAST      4
`define MFS_RX_BCAST      3
`define MFS_RX_FCS_ERR    2
`define MFS_RX_BAD        1
`define MFS_RX_GOOD       0

// Shared length field position
`define MFS_LEN_MSB       19
`define MFS_LEN_LSB       5

// Length limits and frame geometry, in bytes
`define MFS_LEN_JUMBO_CAP 16'h7FFF
`define MFS_LEN_STD_CAP   16'h05EE
`define MFS_LEN_VLAN_CAP  16'h05F2
`define MFS_CTRL_LEN      16'h0040
`define MFS_PAD_LIMIT     16'h002E
`define MFS_HDR_FCS_LEN   16'h0012
`define MFS_TAG_LEN       16'h0004

// Length/type and opcode codes
`define MFS_TYPE_CTRL     16'h8808
`define MFS_TYPE_VLAN     16'h8100
`define MFS_TYPE_MIN      16'h0600
`define MFS_OPC_PAUSE     16'h0001

// Control multicast address, first byte on the wire in the low byte
`define MFS_CTRL_MCAST    48'h0100_00C2_8001
`define MFS_BCAST_ADDR    48'hFFFF_FFFF_FFFF

`endif

// ==== mfs_pkg.sv ====
// Types and shared decoding for the MAC frame statistics block.
// Assumes a 64-bit datapath carrying eight byte lanes per beat.
package mfs_pkg;

	// Header capture position within a frame
	typedef enum {MFS_BEAT_DA, MFS_BEAT_TYPE, MFS_BEAT_INNER, MFS_BEAT_BODY} mfs_beat_t;

	// Number of live byte lanes in one beat, 0 to 8
	function automatic logic [3:0] lane_count(input logic [7:0] lanes);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, lanes[i]};
		end
		return n;
	endfunction

endpackage

// ==== mfs_beat_if.sv ====
// One side of the frame datapath as seen by the statistics logic.
// Assumes every frame starts in byte lane 0 and lanes fill from lane 0 up.
`timescale 1ns/1ps

interface mfs_beat_if;
	logic [63:0] data;   // Byte n of a beat sits in data[8n+7:8n]
	logic [7:0]  lanes;  // Live lanes, DA through FCS only
	logic        first;  // Beat carries the frame's first byte
	logic        last;   // Beat carries the frame's last byte

	modport src (output data, output lanes, output first, output last);
	modport snk (input data, input lanes, input first, input last);
endinterface

// ==== mfs_hdr_parse.sv ====
// Header capture: destination address, length/type and opcode, both plain
// and behind one VLAN tag. Assumes the frame starts in lane 0.
`timescale 1ns/1ps
`include "mfs_defs.svh"

module mfs_hdr_parse (
	input  wire logic   clock,
	input  wire logic   rst,
	mfs_beat_if.snk     beat,
	output logic        da_mcast,
	output logic        da_bcast,
	output logic [47:0] da,
	output logic        vlan_tag,
	output logic [15:0] lt_field,
	output logic [15:0] opcode
);
	mfs_pkg::mfs_beat_t pos_r;
	mfs_pkg::mfs_beat_t cur;
	logic [47:0]        da_r;
	logic [15:0]        t12_r;
	logic [15:0]        o14_r;
	logic [15:0]        t16_r;
	logic [15:0]        o18_r;
	logic               live;

	assign live = |beat.lanes;

	// Position of the current beat; a first beat always restarts capture
	always_comb begin
		cur = beat.first ? mfs_pkg::MFS_BEAT_DA : pos_r;
	end

	////////////////////////////////////////////////////////////////////////
	// Beat position tracking
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pos_r <= mfs_pkg::MFS_BEAT_DA;
		end else if (live) begin
			case (cur)
				mfs_pkg::MFS_BEAT_DA:    pos_r <= mfs_pkg::MFS_BEAT_TYPE;
				mfs_pkg::MFS_BEAT_TYPE:  pos_r <= mfs_pkg::MFS_BEAT_INNER;
				mfs_pkg::MFS_BEAT_INNER: pos_r <= mfs_pkg::MFS_BEAT_BODY;
				default:                 pos_r <= mfs_pkg::MFS_BEAT_BODY;
			endcase
		end
	end

	// Field capture; DA keeps its first wire byte in the low byte, type and opcode are most significant byte first
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			da_r  <= 48'h0000_0000_0000;
			t12_r <= 16'h0000;
			o14_r <= 16'h0000;
			t16_r <= 16'h0000;
			o18_r <= 16'h0000;
		end else if (live) begin
			if (cur == mfs_pkg::MFS_BEAT_DA) begin
				da_r <= beat.data[47:0];
			end
			if (cur == mfs_pkg::MFS_BEAT_TYPE) begin
				t12_r <= {beat.data[39:32], beat.data[47:40]};
				o14_r <= {beat.data[55:48], beat.data[63:56]};
			end
			if (cur == mfs_pkg::MFS_BEAT_INNER) begin
				t16_r <= {beat.data[7:0], beat.data[15:8]};
				o18_r <= {beat.data[23:16], beat.data[31:24]};
			end
		end
	end

	// A tagged frame carries its real type and opcode four bytes later
	assign da       = da_r;
	assign da_mcast = da_r[0];
	assign da_bcast = (da_r == `MFS_BCAST_ADDR);
	assign vlan_tag = (t12_r == `MFS_TYPE_VLAN);
	assign lt_field = vlan_tag ? t16_r : t12_r;
	assign opcode   = vlan_tag ? o18_r : o14_r;
endmodule

// ==== mfs_len_count.sv ====
// Frame byte counter, DA through FCS, saturating at the top of 16 bits.
// Assumes lanes are only live between a first beat and its last beat.
`timescale 1ns/1ps

module mfs_len_count (
	input  wire logic   clock,
	input  wire logic   rst,
	mfs_beat_if.snk     beat,
	output logic [15:0] total
);
	logic [15:0] acc_r;
	logic [16:0] sum;

	// Running total including the present beat, so the last beat counts
	always_comb begin
		sum   = (beat.first ? 17'h0_0000 : {1'b0, acc_r}) + {13'h0000, mfs_pkg::lane_count(beat.lanes)};
		total = sum[16] ? 16'hFFFF : sum[15:0];
	end

	// Saturation keeps very long jumbo frames from wrapping to small values
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_r <= 16'h0000;
		end else if (|beat.lanes) begin
			acc_r <= total;
		end
	end
endmodule

// ==== mfs_stats_client.sv ====
// Client-side model that accumulates frame statistics from both reports.
// Assumes both reports come from the single clock of the statistics block.
`timescale 1ns/1ps

module mfs_stats_client (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [25:0] tx_vec,
	input  wire logic        tx_vld,
	input  wire logic [29:0] rx_vec,
	input  wire logic        rx_vld,
	output logic      [31:0] tx_frames_r,
	output logic      [31:0] rx_frames_r,
	output logic      [31:0] tx_bytes_r,
	output logic      [31:0] rx_bytes_r
);
	////////////////////////////////////////////////////////////////////////////////
	// Frame counts: report fields are only trusted in the strobe cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_frames_r <= 32'h0000_0000;
			rx_frames_r <= 32'h0000_0000;
		end else begin
			tx_frames_r <= tx_frames_r + 32'(tx_vld);
			rx_frames_r <= rx_frames_r + 32'(rx_vld);
		end
	end

	// Byte totals: the count field is summed every cycle, strobe or not
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_bytes_r <= 32'h0000_0000;
			rx_bytes_r <= 32'h0000_0000;
		end else begin
			tx_bytes_r <= tx_bytes_r + 32'(tx_vec[24:21]);
			rx_bytes_r <= rx_bytes_r + 32'(rx_vec[26:23]);
		end
	end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the MAC frame statistics block.
// Assumes one 100 MHz clock for both datapath taps; inputs move 1 ns after the edge.
`timescale 1ns/1ps
`include "mfs_defs.svh"

module tb_top;
	localparam logic [47:0] UC = 48'h0A0B_0C0D_0E02;
	localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
	localparam logic [47:0] CM = `MFS_CTRL_MCAST;
	logic        clock, rst;
	logic [63:0] tx_data, rx_data;
	logic [7:0]  tx_lanes, rx_lanes;
	logic        tx_first, tx_last, tx_underrun, tx_error, tx_pause_gen, tx_vlan_en;
	logic        rx_first, rx_last, rx_fcs_bad, rx_code_err, rx_vlan_en, rx_jumbo_en;
	logic        rx_lt_check_dis, rx_fc_en, tx_stats_vld, rx_stats_vld;
	logic        local_fault_pin, remote_fault_pin;
	logic [47:0] rx_pause_addr;
	logic [25:0] tx_stats_vector;
	logic [29:0] rx_stats_vector;
	logic [1:0]  link_fault_status;
	logic [31:0] tx_frames, rx_frames, tx_bytes, rx_bytes;
	logic [7:0]  hdr [0:19];
	int          errors, samples_checked, cycles, last_cnt;
	int          exp_bytes [2];
	int          exp_frames [2];

	mfs_top u_dut (.clock, .rst, .tx_data, .tx_lanes, .tx_first, .tx_last, .tx_underrun,
		.tx_error, .tx_pause_gen, .tx_vlan_en, .tx_stats_vector, .tx_stats_vld, .rx_data,
		.rx_lanes, .rx_first, .rx_last, .rx_fcs_bad, .rx_code_err, .rx_vlan_en, .rx_jumbo_en,
		.rx_lt_check_dis, .rx_fc_en, .rx_pause_addr, .rx_stats_vector, .rx_stats_vld,
		.local_fault_pin, .remote_fault_pin, .link_fault_status);

	mfs_stats_client u_client (.clock, .rst, .tx_vec(tx_stats_vector), .tx_vld(tx_stats_vld),
		.rx_vec(rx_stats_vector), .rx_vld(rx_stats_vld), .tx_frames_r(tx_frames),
		.rx_frames_r(rx_frames), .tx_bytes_r(tx_bytes), .rx_bytes_r(rx_bytes));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard; the jumbo frame alone needs over 4000 cycles
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Header bytes on the wire: DA low byte first, type and opcode high byte first
	task automatic head(input logic [47:0] da, input logic [15:0] lt, input logic [15:0] opc, input bit tag);
		for (int i = 0; i < 20; i++) hdr[i] = 8'h00;
		for (int i = 0; i < 6; i++) hdr[i] = da[8*i+:8];
		if (tag) begin
			{hdr[12], hdr[13]} = 16'h8100;
			{hdr[16], hdr[17]} = lt;
			{hdr[18], hdr[19]} = opc;
		end else begin
			{hdr[12], hdr[13]} = lt;
			{hdr[14], hdr[15]} = opc;
		end
	endtask

	// Frame of len bytes from lane 0 up; returns in the cycle after the last beat
	task automatic frame(input bit rx, input int len);
		logic [63:0] d;
		logic [7:0]  ln;
		int          rem;
		for (int b = 0; b * 8 < len; b++) begin
			rem = len - b * 8;
			for (int i = 0; i < 8; i++) d[8*i+:8] = (b * 8 + i < 20) ? hdr[b*8+i] : 8'h00;
			ln = (rem >= 8) ? 8'hFF : 8'((1 << rem) - 1);
			last_cnt = (rem >= 8) ? 8 : rem;
			@(posedge clock);
			#1;
			if (rx) begin
				{rx_data, rx_lanes, rx_first, rx_last} = {d, ln, b == 0, rem <= 8};
			end else begin
				{tx_data, tx_lanes, tx_first, tx_last} = {d, ln, b == 0, rem <= 8};
			end
		end
		@(posedge clock);
		#1;
		{tx_lanes, tx_first, tx_last, rx_lanes, rx_first, rx_last} = 20'h0_0000;
		exp_bytes[rx] += len;
		exp_frames[rx]++;
	endtask

	// Report check in the strobe cycle, then strobe and byte count gone a cycle later
	task automatic rep(input bit rx, input logic [29:0] e);
		logic [29:0] v;
		v = rx ? rx_stats_vector & ~30'h0780_0000 : {4'h0, tx_stats_vector} & ~30'h01E0_0000;
		chk("strobe", 32'(rx ? rx_stats_vld : tx_stats_vld), 1);
		chk("report", 32'(v), 32'(e));
		chk("bytes", 32'(rx ? rx_stats_vector[26:23] : tx_stats_vector[24:21]), last_cnt);
		@(posedge clock);
		#1;
		chk("strobe_end", 32'(rx ? rx_stats_vld : tx_stats_vld), 0);
		chk("bytes_idle", 32'(rx ? rx_stats_vector[26:23] : tx_stats_vector[24:21]), 0);
	endtask

	function automatic logic [29:0] txe(input logic p, input logic v, input int len, input logic [4:0] lo);
		return {4'h0, p, 4'h0, v, 15'(len), lo};
	endfunction

	function automatic logic [29:0] rxe(input logic [2:0] hi, input logic [2:0] mid, input int len,
		input logic [4:0] lo);
		return {hi, 4'h0, mid, 15'(len), lo};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: send side, receive side, fault flags, client totals
	initial begin
		{rst, tx_data, rx_data, tx_lanes, rx_lanes} = {1'b1, 144'h0};
		{tx_first, tx_last, tx_underrun, tx_error, tx_pause_gen, tx_vlan_en} = 6'h00;
		{rx_first, rx_last, rx_fcs_bad, rx_code_err, rx_vlan_en, rx_jumbo_en} = 6'h00;
		{rx_lt_check_dis, rx_fc_en, local_fault_pin, remote_fault_pin} = 4'h0;
		rx_pause_addr = 48'h5544_3322_1102;
		repeat (6) @(posedge clock);
		#1;
		rst = 1'b0;
		head(UC, 16'h0800, 16'h0000, 0);
		frame(0, 64);
		rep(0, txe(0, 0, 64, 5'h01));
		tx_error = 1'b1;
		head(BC, 16'h0800, 16'h0000, 0);
		frame(0, 61);
		rep(0, txe(0, 0, 61, 5'h06));
		{tx_error, tx_pause_gen} = 2'h1;
		head(CM, 16'h8808, 16'h0001, 0);
		frame(0, 64);
		rep(0, txe(1, 0, 64, 5'h15));
		{tx_pause_gen, tx_underrun} = 2'h1;
		for (int en = 0; en < 2; en++) begin
			tx_vlan_en = en[0];
			head(UC, 16'h8808, 16'h0001, 1);
			frame(0, 68);
			rep(0, txe(0, en[0], 68, 5'h18));
		end
		tx_underrun = 1'b0;
		head(UC, 16'h0800, 16'h0000, 0);
		frame(0, 33000);
		rep(0, txe(0, 0, 32767, 5'h01));
		frame(1, 64);
		rep(1, rxe(0, 0, 64, 5'h01));
		for (int e = 0; e < 2; e++) begin
			{rx_fcs_bad, rx_code_err} = {~e[0], e[0]};
			head(BC, 16'h0800, 16'h0000, 0);
			frame(1, 67);
			rep(1, rxe(0, 0, 67, 5'h1E));
		end
		{rx_fcs_bad, rx_code_err} = 2'h0;
		for (int fc = 0; fc < 2; fc++) begin
			rx_fc_en = fc[0];
			head(CM, 16'h8808, 16'h0001, 0);
			frame(1, 64);
			rep(1, rxe({2'h0, fc[0]}, 3'h1, 64, 5'h11));
		end
		head(rx_pause_addr, 16'h8808, 16'h0001, 0);
		frame(1, 64);
		rep(1, rxe(3'h1, 3'h1, 64, 5'h01));
		head(UC, 16'h8808, 16'h0002, 0);
		frame(1, 64);
		rep(1, rxe(3'h2, 3'h1, 64, 5'h01));
		rx_vlan_en = 1'b1;
		head(UC, 16'h0800, 16'h0000, 0);
		frame(1, 1600);
		rep(1, rxe(0, 3'h2, 1518, 5'h02));
		head(UC, 16'h0800, 16'h0000, 1);
		frame(1, 1600);
		rep(1, rxe(0, 3'h6, 1522, 5'h02));
		rx_jumbo_en = 1'b1;
		frame(1, 1600);
		rep(1, rxe(0, 3'h4, 1600, 5'h01));
		rx_jumbo_en = 1'b0;
		head(UC, 16'h0064, 16'h0000, 0);
		frame(1, 64);
		rep(1, rxe(3'h4, 0, 64, 5'h02));
		head(UC, 16'h002E, 16'h0000, 0);
		frame(1, 64);
		rep(1, rxe(0, 0, 64, 5'h01));
		head(UC, 16'h0010, 16'h0000, 0);
		frame(1, 70);
		rep(1, rxe(3'h4, 0, 70, 5'h02));
		rx_lt_check_dis = 1'b1;
		frame(1, 70);
		rep(1, rxe(0, 0, 70, 5'h01));
		rx_lt_check_dis = 1'b0;
		head(UC, 16'h002E, 16'h0000, 1);
		frame(1, 68);
		rep(1, rxe(0, 3'h4, 68, 5'h01));
		rx_vlan_en = 1'b0;
		head(UC, 16'h0800, 16'h0000, 1);
		frame(1, 1600);
		rep(1, rxe(0, 3'h2, 1518, 5'h02));
		for (int k = 0; k < 4; k++) begin
			{remote_fault_pin, local_fault_pin} = k[1:0];
			repeat (2) @(posedge clock);
			#1;
			chk("fault", 32'(link_fault_status), k);
		end
		repeat (2) @(posedge clock);
		#1;
		chk("tx_frames", tx_frames, exp_frames[0]);
		chk("rx_frames", rx_frames, exp_frames[1]);
		chk("tx_bytes", tx_bytes, exp_bytes[0]);
		chk("rx_bytes", rx_bytes, exp_bytes[1]);
		close_out();
	end
endmodule
